/* File: hw/lcta_pin_gen.sv */
`default_nettype none

module lcta_pin_gen #(
   parameter int CW = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire lcta_pkg::lcta_pin_mode_type i_mode,
   input wire logic i_level,
   input wire logic i_fire,
   input wire logic [CW-1:0] i_period,
   input wire logic [CW-1:0] i_width,
   output logic o_pin
);
   import lcta_pkg::*;

   logic [CW-1:0] cnt_ff;
   logic busy_ff;

   // ---------------------------------------------------------------
   // shared counter serves both the one-shot and the pwm wave
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
      end else if (i_mode == PIN_PWM) begin
         busy_ff <= 1'b0;
         cnt_ff <= (cnt_ff + 1'b1 >= i_period) ? '0 : cnt_ff + 1'b1;
      end else if (i_mode == PIN_PULSE && i_fire && !busy_ff) begin
         busy_ff <= 1'b1;
         cnt_ff <= '0;
      end else if (busy_ff) begin
         // retrigger while busy is ignored so pulse width stays exact
         cnt_ff <= cnt_ff + 1'b1;
         busy_ff <= (cnt_ff + 1'b1 < i_width);
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_pin <= 1'b0;
      end else begin
         unique case (i_mode)
            PIN_LEVEL: o_pin <= i_level;
            PIN_PULSE: o_pin <= busy_ff;
            PIN_PWM: o_pin <= (cnt_ff < i_width);
            default: o_pin <= 1'b0;
         endcase
      end
   end
endmodule // lcta_pin_gen

`default_nettype wire

/* File: hw/lcta_top.sv */
//Function
//- each line is 2086 slots: dummy, optical black, dummy, active 33-2080, dummy.
//- ignore sensor output until 22500 sensor clock pulses issued after reset.
//- expose-transfer-readout pipeline; line read belongs to the previous exposure.
//- no sample-and-hold; one reset level per pixel, front end does correlated double sampling.
//- pixel values are unsigned 16-bit counts, full scale 65535.
//- dark baseline near 1000 counts, front end offset adjustable by command.
//- single mode waits one trigger, then takes exactly one spectrum.
//- trigger edge selectable rising or falling; only that edge starts capture.
//- frames mode: one trigger captures preset count of back-to-back spectra.
//- list mode: one spectrum per trigger using next preloaded integration time.
//- captured spectra go to on-board store holding up to 4000 spectra.
//- upload to host held back until all programmed integrations finish.
//- dedicated output switches the external light source on.
//- two general outputs with software-set levels.
//- six user pins: software level, single pulse or pwm.
`include "lcta_params.svh"
`default_nettype none

module lcta_top #(
   parameter int WARMUP_PULSES = `LCTA_WARMUP_PULSES,
   parameter int SCLK_HALF = `LCTA_SCLK_HALF,
   parameter int LIST_DEPTH = `LCTA_LIST_DEPTH,
   parameter int PINS = `LCTA_USER_PINS,
   parameter int TW = 24
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // sensor and front end
   output logic o_ccd_clk,
   output logic o_xfer_gate,
   output logic o_corr_reset_smp,
   output logic o_corr_data_smp,
   output logic [15:0] o_afe_offset,
   input wire logic [15:0] i_afe_data,
   // acquisition control
   input wire lcta_pkg::lcta_mode_type i_mode,
   input wire logic i_edge_rising,
   input wire logic i_trig,
   input wire logic [TW-1:0] i_itime,
   input wire logic [11:0] i_frames,
   input wire logic [15:0] i_offset,
   input wire logic i_offset_load,
   input wire logic i_list_wr,
   input wire logic [$clog2(LIST_DEPTH)-1:0] i_list_addr,
   input wire logic [TW-1:0] i_list_data,
   input wire logic [$clog2(LIST_DEPTH):0] i_list_len,
   // spectrum store and host upload
   output logic o_pix_valid,
   output logic [15:0] o_pix_data,
   output logic [11:0] o_pix_slot,
   output lcta_pkg::lcta_pix_class_type o_pix_class,
   output logic [11:0] o_store_wr_idx,
   output logic o_spec_done,
   output logic [11:0] o_store_count,
   input wire logic i_spec_release,
   output logic o_upload_ready,
   output logic o_overflow,
   input wire logic i_overflow_clr,
   output logic o_warm,
   output logic o_busy,
   // extension connector outputs
   input wire logic i_light_on,
   output logic o_light_source_on,
   input wire logic i_user_out_zero,
   input wire logic i_user_out_one,
   output logic o_user_out_zero,
   output logic o_user_out_one,
   input wire lcta_pkg::lcta_pin_mode_type i_pin_mode [PINS],
   input wire logic [PINS-1:0] i_pin_level,
   input wire logic [PINS-1:0] i_pin_fire,
   input wire logic [15:0] i_pin_period,
   input wire logic [15:0] i_pin_width,
   output logic [PINS-1:0] o_user_pin
);
   import lcta_pkg::*;

   localparam int PW = $clog2(2 * SCLK_HALF);
   localparam int LW = $clog2(LIST_DEPTH);
   localparam logic [PW-1:0] PH_LAST = PW'(2 * SCLK_HALF - 1);
   localparam logic [PW-1:0] PH_HALF = PW'(SCLK_HALF);
   localparam logic [15:0] WARM_LAST = 16'(WARMUP_PULSES - 1);

   // ---------------------------------------------------------------
   // slot classification, used only for output tagging; store gating does not use it
   // ---------------------------------------------------------------
   // slot map
   function automatic lcta_pix_class_type slot_class(input logic [11:0] s);
      if (s <= `LCTA_DUMMY_A_LAST) return PIX_DUMMY;
      if (s <= `LCTA_BLACK_LAST) return PIX_BLACK;
      if (s <= `LCTA_DUMMY_B_LAST) return PIX_DUMMY;
      if (s <= `LCTA_ACTIVE_LAST) return PIX_ACTIVE;
      return PIX_DUMMY;
   endfunction

   logic [PW-1:0] phase_ff;
   logic pix_tick;
   logic [11:0] slot_ff;
   logic line_end;
   logic [15:0] warm_cnt_ff;
   logic warm_ff;
   logic [TW-1:0] expo_cnt_ff;
   logic [TW-1:0] itime_cur_ff;
   logic xfer;
   logic exp_cap_ff;
   logic rd_cap_ff;
   logic keep_ff;
   logic [11:0] frames_left_ff;
   logic [LW-1:0] list_idx_ff;
   logic [TW-1:0] list_mem [LIST_DEPTH];
   logic seq_open_ff;
   logic trig_edge;
   logic trig_take;
   logic busy;
   logic [11:0] store_cnt_ff;
   logic store_full;
   logic line_kept;

   // ---------------------------------------------------------------
   // sensor clock divider and correlated double sampling strobes
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         phase_ff <= '0;
      end else begin
         phase_ff <= (phase_ff == PH_LAST) ? '0 : phase_ff + 1'b1;
      end
   end

   assign pix_tick = (phase_ff == PH_LAST);

   // reset then data sample per pixel
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_ccd_clk <= 1'b0;
         o_corr_reset_smp <= 1'b0;
         o_corr_data_smp <= 1'b0;
      end else begin
         o_ccd_clk <= (phase_ff < PH_HALF);
         o_corr_reset_smp <= (phase_ff == PW'(1));
         o_corr_data_smp <= (phase_ff == PH_HALF + PW'(1));
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_afe_offset <= `LCTA_OFFSET_RESET;
      end else if (i_offset_load) begin
         o_afe_offset <= i_offset;
      end
   end

   // ---------------------------------------------------------------
   // warm-up count of sensor clock pulses
   // ---------------------------------------------------------------
   // hold off until enough pulses
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         warm_cnt_ff <= '0;
         warm_ff <= 1'b0;
      end else if (pix_tick && !warm_ff) begin
         warm_cnt_ff <= warm_cnt_ff + 1'b1;
         warm_ff <= (warm_cnt_ff == WARM_LAST);
      end
   end

   // ---------------------------------------------------------------
   // line slot counter, runs free so the sensor is always flushed
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         slot_ff <= 12'h001;
      end else if (pix_tick) begin
         slot_ff <= (slot_ff == `LCTA_LINE_SLOTS) ? 12'h001 : slot_ff + 12'h001;
      end
   end

   assign line_end = pix_tick && (slot_ff == `LCTA_LINE_SLOTS);

   // ---------------------------------------------------------------
   // exposure timer; transfer only at a line boundary, so the
   // shortest exposure is one line readout
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         expo_cnt_ff <= '0;
      end else if (xfer) begin
         expo_cnt_ff <= '0;
      end else if (pix_tick && expo_cnt_ff != '1) begin
         expo_cnt_ff <= expo_cnt_ff + 1'b1;
      end
   end

   // transfer ends one exposure
   // one spare bit so a saturated timer cannot wrap and stall the transfer
   assign xfer = line_end && ((TW+1)'(expo_cnt_ff) + (TW+1)'(1) >= (TW+1)'(itime_cur_ff));

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_xfer_gate <= 1'b0;
      end else if (pix_tick) begin
         o_xfer_gate <= xfer;
      end
   end

   // ---------------------------------------------------------------
   // trigger intake
   // ---------------------------------------------------------------
   lcta_trig_sync u_trig (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_trig(i_trig),
      .i_rising(i_edge_rising),
      .o_edge(trig_edge)
   );

   assign busy = (frames_left_ff != '0) || exp_cap_ff || rd_cap_ff;
   assign trig_take = trig_edge && warm_ff && !busy;

   // integration list, written by software before the triggers arrive
   always_ff @(posedge i_sys_clk) begin
      if (i_list_wr) begin
         list_mem[i_list_addr] <= i_list_data;
      end
   end

   // ---------------------------------------------------------------
   // frame sequencing: pending frames enter the exposure pipe
   // one per transfer, with no idle exposure between them
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         frames_left_ff <= '0;
         exp_cap_ff <= 1'b0;
         rd_cap_ff <= 1'b0;
         itime_cur_ff <= TW'(`LCTA_LINE_SLOTS);
      end else begin
         if (trig_take) begin
            unique case (i_mode)
               MODE_ONE_SHOT: frames_left_ff <= 12'h001;
               MODE_ONE_TRIG_FRAMES: frames_left_ff <= i_frames;
               MODE_TRIG_LIST: frames_left_ff <= 12'h001;
               default: frames_left_ff <= 12'h000;
            endcase
         end else if (xfer) begin
            rd_cap_ff <= exp_cap_ff;
            exp_cap_ff <= (frames_left_ff != '0);
            if (frames_left_ff != '0) begin
               frames_left_ff <= frames_left_ff - 12'h001;
               itime_cur_ff <= (i_mode == MODE_TRIG_LIST) ? list_mem[list_idx_ff] : i_itime;
            end else begin
               itime_cur_ff <= TW'(`LCTA_LINE_SLOTS);
            end
         end
      end
   end

   // list position steps as each capture starts, so the first capture uses entry zero
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         list_idx_ff <= '0;
         seq_open_ff <= 1'b0;
      end else if (xfer && frames_left_ff != '0) begin
         if (i_mode == MODE_TRIG_LIST) begin
            list_idx_ff <= list_idx_ff + 1'b1;
            seq_open_ff <= ({1'b0, list_idx_ff} + 1'b1 < i_list_len);
            if ({1'b0, list_idx_ff} + 1'b1 >= i_list_len) begin
               list_idx_ff <= '0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // pixel output toward the spectrum store
   // ---------------------------------------------------------------
   assign store_full = (store_cnt_ff >= `LCTA_STORE_DEPTH);

   // decide keep or drop per line
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         keep_ff <= 1'b0;
      end else if (xfer) begin
         keep_ff <= exp_cap_ff && !store_full;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_pix_valid <= 1'b0;
         o_pix_data <= 16'h0000;
         o_pix_slot <= 12'h000;
         o_pix_class <= PIX_DUMMY;
      end else begin
         o_pix_valid <= pix_tick && warm_ff && rd_cap_ff && keep_ff;
         if (pix_tick) begin
            o_pix_data <= i_afe_data;
            o_pix_slot <= slot_ff;
            o_pix_class <= slot_class(slot_ff);
         end
      end
   end

   assign line_kept = line_end && rd_cap_ff && keep_ff;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_spec_done <= 1'b0;
      end else begin
         o_spec_done <= line_kept;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         store_cnt_ff <= '0;
         o_store_wr_idx <= '0;
      end else begin
         if (line_kept) begin
            o_store_wr_idx <= (o_store_wr_idx == `LCTA_STORE_DEPTH - 12'h001) ?
               12'h000 : o_store_wr_idx + 12'h001;
         end
         if (line_kept && !(i_spec_release && store_cnt_ff != '0)) begin
            store_cnt_ff <= store_cnt_ff + 12'h001;
         end else if (!line_kept && i_spec_release && store_cnt_ff != '0) begin
            store_cnt_ff <= store_cnt_ff - 12'h001;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_overflow <= 1'b0;
      end else if (xfer && exp_cap_ff && store_full) begin
         o_overflow <= 1'b1;
      end else if (i_overflow_clr) begin
         o_overflow <= 1'b0;
      end
   end

   assign o_upload_ready = !busy && !seq_open_ff && (store_cnt_ff != '0);
   assign o_store_count = store_cnt_ff;
   assign o_warm = warm_ff;
   assign o_busy = busy;

   // ---------------------------------------------------------------
   // extension connector outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_light_source_on <= 1'b0;
         o_user_out_zero <= 1'b0;
         o_user_out_one <= 1'b0;
      end else begin
         o_light_source_on <= i_light_on;
         o_user_out_zero <= i_user_out_zero;
         o_user_out_one <= i_user_out_one;
      end
   end

   for (genvar k = 0; k < PINS; k++) begin : g_pin
      lcta_pin_gen #(
         .CW(16)
      ) u_pin (
         .i_sys_clk(i_sys_clk),
         .i_reset(i_reset),
         .i_mode(i_pin_mode[k]),
         .i_level(i_pin_level[k]),
         .i_fire(i_pin_fire[k]),
         .i_period(i_pin_period),
         .i_width(i_pin_width),
         .o_pin(o_user_pin[k])
      );
   end
endmodule // lcta_top

`default_nettype wire

/* File: hw/lcta_trig_sync.sv */
`default_nettype none

module lcta_trig_sync (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_trig,
   input wire logic i_rising,
   output logic o_edge
);
   import lcta_pkg::*;

   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   // ---------------------------------------------------------------
   // two-stage synchroniser, then edge history
   // ---------------------------------------------------------------
   // two stage sync
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= i_trig;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign o_edge = i_rising ? (sync_ff & ~last_ff) : (~sync_ff & last_ff);
endmodule // lcta_trig_sync

`default_nettype wire

/* File: inc/lcta_params.svh */
`ifndef LCTA_PARAMS_SVH
`define LCTA_PARAMS_SVH

// pixel slot map of one readout line (slots numbered from 1)
`define LCTA_LINE_SLOTS 12'h826
`define LCTA_DUMMY_A_LAST 12'h00c
`define LCTA_BLACK_LAST 12'h01e
`define LCTA_DUMMY_B_LAST 12'h020
`define LCTA_ACTIVE_LAST 12'h820

// sensor clock pulses to issue before the output is trusted
`define LCTA_WARMUP_PULSES 22500

// sensor clock half period in system clock cycles
`define LCTA_SCLK_HALF 4

// front end offset reset value giving a dark baseline near 1000 counts
`define LCTA_OFFSET_RESET 16'h03e8

// capacity of the spectrum store
`define LCTA_STORE_DEPTH 12'hfa0

// integration list depth and pin count
`define LCTA_LIST_DEPTH 16
`define LCTA_USER_PINS 6

`endif

/* File: inc/lcta_pkg.sv */
`default_nettype none

package lcta_pkg;
   // acquisition trigger modes
   typedef enum logic [1:0] {
      MODE_ONE_SHOT,
      MODE_ONE_TRIG_FRAMES,
      MODE_TRIG_LIST
   } lcta_mode_type;

   // class of a pixel slot inside a line
   typedef enum logic [1:0] {
      PIX_DUMMY,
      PIX_BLACK,
      PIX_ACTIVE
   } lcta_pix_class_type;

   // user pin behaviour
   typedef enum logic [1:0] {
      PIN_LEVEL,
      PIN_PULSE,
      PIN_PWM
   } lcta_pin_mode_type;
endpackage

`default_nettype wire

/* File: testbench/lcta_checker.sv */
`default_nettype none

module lcta_checker #(
   parameter int WARMUP_PULSES = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic o_ccd_clk,
   input wire logic o_corr_reset_smp,
   input wire logic o_corr_data_smp,
   input wire logic [15:0] o_afe_offset,
   input wire logic [15:0] i_offset,
   input wire logic i_offset_load,
   input wire logic o_pix_valid,
   input wire logic [11:0] o_pix_slot,
   input wire lcta_pkg::lcta_pix_class_type o_pix_class,
   input wire logic o_spec_done,
   input wire logic o_upload_ready,
   input wire logic o_busy,
   input wire logic o_overflow,
   input wire logic i_overflow_clr,
   input wire logic o_warm
);
   timeunit 1ns;
   timeprecision 1ps;
   import lcta_pkg::*;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_reset);
   logic clk_q_ff;
   int pulses_ff;

   // sensor pulses since reset, saturating so a long run never wraps
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         clk_q_ff <= 1'b0;
         pulses_ff <= 0;
      end else begin
         clk_q_ff <= o_ccd_clk;
         if (o_ccd_clk && !clk_q_ff && pulses_ff < WARMUP_PULSES) begin
            pulses_ff <= pulses_ff + 1;
         end
      end
   end

   a_warm_after_count: assert property (
      o_warm |-> (pulses_ff + int'(o_ccd_clk && !clk_q_ff)) >= WARMUP_PULSES)
      else $error("warm flag before warm-up count");
   a_no_cold_pixel: assert property (
      o_pix_valid |-> o_warm) else $error("pixel before warm-up");
   a_slot_step: assert property (
      o_pix_valid && o_pix_slot < 12'h826 |->
      ##8 (o_pix_valid && o_pix_slot == $past(o_pix_slot, 8) + 12'h001))
      else $error("pixel slot spacing wrong");
   a_slot_class: assert property (
      o_pix_valid |-> o_pix_class == ((o_pix_slot >= 12'h021 && o_pix_slot <= 12'h820) ?
      PIX_ACTIVE : (o_pix_slot >= 12'h00d && o_pix_slot <= 12'h01e) ? PIX_BLACK : PIX_DUMMY))
      else $error("pixel class wrong");
   a_done_last_slot: assert property (
      $rose(o_spec_done) |-> o_pix_slot == 12'h826) else $error("line ended early");
   a_sample_pair: assert property (
      o_corr_reset_smp |-> ##4 o_corr_data_smp) else $error("data sample missing");
   a_upload_held: assert property (
      o_busy |-> !o_upload_ready) else $error("upload ready while busy");
   a_overflow_sticky: assert property (
      o_overflow && !i_overflow_clr |=> o_overflow) else $error("overflow lost");
   a_offset_load: assert property (
      i_offset_load |=> o_afe_offset == $past(i_offset)) else $error("offset not loaded");
endmodule // lcta_checker

bind lcta_top lcta_checker #(.WARMUP_PULSES(WARMUP_PULSES)) u_lcta_checker (
   .i_sys_clk, .i_reset, .o_ccd_clk, .o_corr_reset_smp, .o_corr_data_smp, .o_afe_offset,
   .i_offset, .i_offset_load, .o_pix_valid, .o_pix_slot, .o_pix_class, .o_spec_done,
   .o_upload_ready, .o_busy, .o_overflow, .i_overflow_clr, .o_warm);

`default_nettype wire

/* File: testbench/lcta_sensor_model.sv */
`default_nettype none

module lcta_sensor_model (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_corr_reset_smp,
   input wire logic i_pulse_req,
   output logic [15:0] o_afe_data,
   output logic o_trig
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 33267;
   int npix;
   int left;

   // new level per pixel, every 16th at full scale
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         o_afe_data <= 16'h0000;
         npix <= 0;
      end else if (i_corr_reset_smp) begin
         npix <= npix + 1;
         o_afe_data <= (npix % 16 == 15) ? 16'hffff : 16'($random(seed));
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         left <= 0;
      end else if (i_pulse_req) begin
         left <= 8;
      end else if (left > 0) begin
         left <= left - 1;
      end
   end
   assign o_trig = (left > 0);
endmodule // lcta_sensor_model

`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import lcta_pkg::*;
   logic i_sys_clk = 1'b0, i_reset = 1'b1, i_edge_rising = 1'b0, i_offset_load = 1'b0;
   logic i_list_wr = 1'b0, i_spec_release = 1'b0, i_overflow_clr = 1'b0, i_light_on = 1'b0;
   logic i_user_out_zero = 1'b0, i_user_out_one = 1'b0, pulse_req = 1'b0;
   logic [15:0] i_offset = 16'h0000, i_pin_period = 16'h000a, i_pin_width = 16'h0005, v;
   logic [23:0] i_itime = 24'h000001, i_list_data = 24'h000001;
   logic [11:0] i_frames = 12'h002;
   logic [3:0] i_list_addr = 4'h0;
   logic [4:0] i_list_len = 5'h01;
   logic [5:0] i_pin_level = 6'h00, i_pin_fire = 6'h00;
   lcta_mode_type i_mode = MODE_ONE_TRIG_FRAMES;
   lcta_pin_mode_type i_pin_mode [6] = '{PIN_LEVEL, PIN_PULSE, PIN_PWM, PIN_LEVEL,
      PIN_LEVEL, PIN_LEVEL};
   logic o_ccd_clk, o_xfer_gate, o_corr_reset_smp, o_corr_data_smp, i_trig, o_pix_valid;
   logic o_spec_done, o_upload_ready, o_overflow, o_warm, o_busy, o_light_source_on;
   logic o_user_out_zero, o_user_out_one;
   logic [15:0] o_afe_offset, i_afe_data, o_pix_data;
   logic [11:0] o_pix_slot, o_store_wr_idx, o_store_count;
   logic [5:0] o_user_pin;
   lcta_pix_class_type o_pix_class;
   int err_count = 0, n_checks = 0, cycles = 0, seed = 33267, nslot = 0, hi1 = 0, hi2 = 0;
   int smp_q[$], done_q[$];

   // warm-up shortened so a run fits the cycle budget
   lcta_top #(.WARMUP_PULSES(4)) u_lcta_top (
      .i_sys_clk, .i_reset, .o_ccd_clk, .o_xfer_gate, .o_corr_reset_smp, .o_corr_data_smp,
      .o_afe_offset, .i_afe_data, .i_mode, .i_edge_rising, .i_trig, .i_itime, .i_frames,
      .i_offset, .i_offset_load, .i_list_wr, .i_list_addr, .i_list_data, .i_list_len,
      .o_pix_valid, .o_pix_data, .o_pix_slot, .o_pix_class, .o_store_wr_idx, .o_spec_done,
      .o_store_count, .i_spec_release, .o_upload_ready, .o_overflow, .i_overflow_clr,
      .o_warm, .o_busy, .i_light_on, .o_light_source_on, .i_user_out_zero, .i_user_out_one,
      .o_user_out_zero, .o_user_out_one, .i_pin_mode, .i_pin_level, .i_pin_fire,
      .i_pin_period, .i_pin_width, .o_user_pin);
   lcta_sensor_model u_lcta_sensor_model (.i_sys_clk, .i_reset,
      .i_corr_reset_smp(o_corr_reset_smp), .i_pulse_req(pulse_req), .o_afe_data(i_afe_data),
      .o_trig(i_trig));

   // 40 MHz clock
   initial begin
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic [1:0] exp_class(input int s);
      if (s >= 33 && s <= 2080) return 2'h2;
      if (s >= 13 && s <= 30) return 2'h1;
      return 2'h0;
   endfunction

   // model of the pixel stream; also the hang limit, above four lines of sensor time
   always @(posedge i_sys_clk) begin
      cycles++;
      if (o_corr_data_smp === 1'b1) smp_q.push_back(i_afe_data);
      if (o_pix_valid === 1'b1) begin
         nslot++;
         check("pixel data", o_pix_data, smp_q[$]);
         check("slot", o_pix_slot, nslot);
         check("class", o_pix_class, exp_class(nslot));
      end
      if (o_spec_done === 1'b1) begin
         check("slots per line", nslot, 2086);
         check("transfer gate", o_xfer_gate, 1'b1);
         nslot = 0;
         done_q.push_back(cycles);
      end
      if (o_user_pin[1] === 1'b1) hi1++;
      if (o_user_pin[2] === 1'b1) hi2++;
      if (cycles == 90000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic fire_trig();
      tick(1);
      pulse_req <= 1'b1;
      tick(1);
      pulse_req <= 1'b0;
   endtask

   task automatic wait_warm();
      for (int k = 0; k < 200 && o_warm !== 1'b1; k++) tick(1);
      #1;
      check("warm", o_warm, 1'b1);
   endtask

   initial begin
      tick(2);
      i_reset <= 1'b0;
      v = 16'($random(seed));
      #1;
      check("offset reset", o_afe_offset, 16'h03e8);
      check("cold", o_warm, 1'b0);
      tick(1);
      i_offset <= v;
      i_offset_load <= 1'b1;
      {i_pin_level, i_user_out_one, i_user_out_zero, i_light_on} <= v[8:0];
      tick(1);
      i_offset_load <= 1'b0;
      tick(2);
      #1;
      check("offset load", o_afe_offset, v);
      check("light", o_light_source_on, v[0]);
      check("out zero", o_user_out_zero, v[1]);
      check("out one", o_user_out_one, v[2]);
      check("level pins", o_user_pin & 6'h39, v[8:3] & 6'h39);
      hi1 = 0;
      hi2 = 0;
      tick(1);
      i_pin_fire <= 6'h02;
      tick(1);
      i_pin_fire <= 6'h00;
      tick(18);
      #1;
      check("pulse width", hi1, 5);
      check("pwm duty", hi2, 10);
      $display("test pins done");
      wait_warm();
      fire_trig();
      tick(5);
      #1;
      check("busy on rising", o_busy, 1'b0);
      tick(12);
      #1;
      check("busy on falling", o_busy, 1'b1);
      tick(200);
      fire_trig();
      for (int k = 0; k < 100000 && o_busy !== 1'b0; k++) tick(1);
      tick(3);
      #1;
      check("spectra", done_q.size(), 2);
      check("frame gap", done_q[1] - done_q[0], 16688);
      check("held", o_store_count, 2);
      check("store index", o_store_wr_idx, 2);
      check("upload ready", o_upload_ready, 1'b1);
      $display("test frames done");
      repeat (3) begin
         tick(1);
         i_spec_release <= 1'b1;
         i_overflow_clr <= 1'b1;
         tick(1);
         i_spec_release <= 1'b0;
         i_overflow_clr <= 1'b0;
      end
      tick(1);
      #1;
      check("drained", o_store_count, 0);
      check("ready empty", o_upload_ready, 1'b0);
      check("overflow", o_overflow, 1'b0);
      $display("test release done");
      tick(1);
      i_mode <= MODE_ONE_SHOT;
      i_edge_rising <= 1'b1;
      fire_trig();
      tick(8);
      #1;
      check("one shot start", o_busy, 1'b1);
      $display("test one shot done");
      tick(1);
      i_reset <= 1'b1;
      i_mode <= MODE_TRIG_LIST;
      tick(2);
      i_reset <= 1'b0;
      i_list_wr <= 1'b1;
      tick(1);
      i_list_wr <= 1'b0;
      wait_warm();
      fire_trig();
      tick(8);
      #1;
      check("list start", o_busy, 1'b1);
      $display("test list done");
      end_of_test();
   end
endmodule // testbench

`default_nettype wire
